// ---- sqc_pkg.sv ----
// shared constants, register map and types for the link quick-configuration block
package sqc_pkg;

   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned ADR_W = 14;

   // -----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [11:0] REG_DCM_IDX = 12'h201;
   localparam logic [11:0] REG_LRC_IDX = 12'h56E;
   localparam logic [11:0] REG_PLL_IDX = 12'h56F;
   localparam logic [11:0] REG_QC_IDX = 12'h570;
   localparam logic [11:0] REG_CTRL_IDX = 12'h571;
   localparam logic [11:0] REG_RES_IDX = 12'h572;
   localparam logic [11:0] REG_CLKLO_IDX = 12'h573;
   localparam logic [11:0] REG_CLKHI_IDX = 12'h574;
   localparam logic [11:0] REG_STAT_IDX = 12'h575;
   localparam logic [11:0] REG_RATELO_IDX = 12'h576;
   localparam logic [11:0] REG_RATEHI_IDX = 12'h577;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int unsigned LRC_LOW_BIT = 4;
   localparam int unsigned PLL_LOCK_BIT = 7;
   localparam int unsigned CTRL_PWRDN_BIT = 0;
   localparam int unsigned CTRL_NP8_BIT = 1;
   localparam int unsigned CTRL_DDC_LSB = 2;
   localparam int unsigned CTRL_CPLX_BIT = 4;
   localparam int unsigned RES_N_LSB = 0;
   localparam int unsigned RES_CS_LSB = 5;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] DCM_RST = 8'h01;
   localparam logic [7:0] LRC_RST = 8'h00;
   localparam logic [7:0] QC_RST = 8'h81;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] RES_RST = 8'h0E;
   localparam logic [7:0] CLKLO_RST = 8'hE8;
   localparam logic [7:0] CLKHI_RST = 8'h03;

   // -----------------------------------------------------------------
   // lane rate limits in Mbps, and lock timing
   // -----------------------------------------------------------------
   localparam logic [15:0] RATE_MIN_MBPS = 16'h0C35;
   localparam logic [15:0] RATE_LOW_MBPS = 16'h186A;
   localparam logic [15:0] RATE_MAX_MBPS = 16'h30D4;
   localparam int unsigned LOCK_TIME_NS = 10000;
   localparam int unsigned LOCK_CYC = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      SQC_DOWN = 2'b00,
      SQC_LOCK = 2'b01,
      SQC_UP = 2'b10
   } sqc_state_e;

   typedef struct packed {
      logic [2:0] lanes;
      logic [2:0] convs;
      logic [3:0] octets;
      logic [3:0] samples;
      logic hd;
      logic ok;
   } sqc_cfg_s;

endpackage

// ---- sqc_qcfg_decode.sv ----
// quick-configuration code to transport-layer settings lookup
`timescale 1ns/10ps
module sqc_qcfg_decode
   import sqc_pkg::*;
(
   input wire logic [7:0] code_i,
   input wire logic nprime8_i,
   output sqc_cfg_s cfg_o
);

   function automatic sqc_cfg_s mk(input int l, input int m, input int f,
                                   input int s, input logic hd);
      sqc_cfg_s c;
      c.lanes = 3'(l);
      c.convs = 3'(m);
      c.octets = 4'(f);
      c.samples = 4'(s);
      c.hd = hd;
      c.ok = 1'b1;
      return c;
   endfunction

   always_comb begin
      cfg_o = '0;
      if (!nprime8_i) begin
         case (code_i)
            8'h01: cfg_o = mk(1, 1, 2, 1, 1'b0);
            8'h40: cfg_o = mk(2, 1, 1, 1, 1'b1);
            8'h41: cfg_o = mk(2, 1, 2, 2, 1'b0);
            8'h80: cfg_o = mk(4, 1, 1, 2, 1'b1);
            8'h81: cfg_o = mk(4, 1, 2, 4, 1'b0);
            8'h0A: cfg_o = mk(1, 2, 4, 1, 1'b0);
            8'h49: cfg_o = mk(2, 2, 2, 1, 1'b0);
            8'h88: cfg_o = mk(4, 2, 1, 1, 1'b1);
            8'h89: cfg_o = mk(4, 2, 2, 2, 1'b0);
            8'h13: cfg_o = mk(1, 4, 8, 1, 1'b0);
            8'h52: cfg_o = mk(2, 4, 4, 1, 1'b0);
            8'h91: cfg_o = mk(4, 4, 2, 1, 1'b0);
            default: cfg_o = '0;
         endcase
      end else begin
         case (code_i)
            8'h00: cfg_o = mk(1, 1, 1, 1, 1'b0);
            8'h01: cfg_o = mk(1, 1, 2, 2, 1'b0);
            8'h40: cfg_o = mk(2, 1, 1, 2, 1'b0);
            8'h41: cfg_o = mk(2, 1, 2, 4, 1'b0);
            8'h42: cfg_o = mk(2, 1, 4, 8, 1'b0);
            8'h80: cfg_o = mk(4, 1, 1, 4, 1'b0);
            8'h81: cfg_o = mk(4, 1, 2, 8, 1'b0);
            8'h09: cfg_o = mk(1, 2, 2, 1, 1'b0);
            8'h48: cfg_o = mk(2, 2, 1, 1, 1'b0);
            8'h49: cfg_o = mk(2, 2, 2, 2, 1'b0);
            8'h88: cfg_o = mk(4, 2, 1, 2, 1'b0);
            8'h89: cfg_o = mk(4, 2, 2, 4, 1'b0);
            8'h8A: cfg_o = mk(4, 2, 4, 8, 1'b0);
            default: cfg_o = '0;
         endcase
      end
   end

endmodule

// ---- sqc_rate_div.sv ----
// sequential restoring divider for the lane rate
`timescale 1ns/10ps
module sqc_rate_div (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic [31:0] num_i,
   input wire logic [15:0] den_i,
   output logic busy_o,
   output logic done_o,
   output logic [31:0] quo_o
);

   logic [31:0] num_r;
   logic [16:0] rem_r;
   logic [5:0] cnt_r;
   logic [16:0] trial;

   assign trial = {rem_r[15:0], num_r[31]};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         num_r <= '0;
         rem_r <= '0;
         cnt_r <= '0;
         quo_o <= '0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            num_r <= num_i;
            rem_r <= '0;
            cnt_r <= 6'h20;
         end else if (busy_o) begin
            // one quotient bit per cycle, msb first
            if (trial >= {1'b0, den_i}) begin
               rem_r <= trial - {1'b0, den_i};
               num_r <= {num_r[30:0], 1'b1};
            end else begin
               rem_r <= trial;
               num_r <= {num_r[30:0], 1'b0};
            end
            cnt_r <= cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               quo_o <= {num_r[30:0], (trial >= {1'b0, den_i})};
            end
         end
      end
   end

endmodule

// ---- sqc_link_cfg.sv ----
// link quick-configuration control with wishbone register access
`timescale 1ns/10ps

// Function
// - the first L of the four serial lanes (1, 2 or 4) form one link; no second link exists.
// - lanes, converters and octets come from the quick-configuration code.
// - with downconverters, link converter count equals virtual converter count.
// - lane rate is M times N' times 10/8 times fout over L.
// - fout is sample clock divided by the decimation ratio register.
// - N'=16 single-converter codes map to fixed L/F/S/HD sets.
// - N'=16 two- and four-converter codes map to fixed L/F/S/HD sets.
// - N'=8 single-converter codes map to fixed L/F/S sets.
// - N'=8 two-converter codes map to fixed L/F/S sets.
// - serializer clock lock is reported in a read-only status bit.
// - complex outputs put I on even and Q on odd converters.
module sqc_link_cfg
   import sqc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [3:0] serial_lane_outputs_en_o,
   output sqc_cfg_s link_cfg_o,
   output logic link_nprime8_o,
   output logic link_up_o,
   output logic [15:0] lane_rate_mbps_o,
   output logic [3:0] conv_q_slot_o
);

   // -----------------------------------------------------------------
   // registers and internal signals
   // -----------------------------------------------------------------
   logic [7:0] dcm_r;
   logic [7:0] lrc_r;
   logic [7:0] qc_r;
   logic [7:0] ctrl_r;
   logic [7:0] res_r;
   logic [7:0] clklo_r;
   logic [7:0] clkhi_r;
   logic [15:0] rate_r;
   logic have_rate_r;
   logic dirty_r;
   logic lock_r;
   logic [10:0] lock_cnt_r;
   sqc_state_e state_r;
   sqc_state_e state_nxt;
   sqc_cfg_s dec_cfg;
   logic [2:0] virt_m;
   logic m_ok;
   logic res_ok;
   logic cfg_ok;
   logic rate_ok;
   logic low_need;
   logic lrc_match;
   logic rate_fresh;
   logic all_ok;
   logic [4:0] res_n;
   logic [1:0] res_cs;
   logic [31:0] num;
   logic [15:0] den;
   logic [4:0] nprime;
   logic div_busy;
   logic div_done;
   logic [31:0] div_quo;
   logic wb_req;
   logic wb_wr;
   logic [11:0] reg_idx;
   logic idx_ok;
   logic [7:0] rd_byte;

   function automatic logic hit(input logic [11:0] idx, input logic [11:0] want);
      return idx == want;
   endfunction

   // -----------------------------------------------------------------
   // wishbone slave
   // -----------------------------------------------------------------
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
   assign reg_idx = wb_adr_i[13:2];
   assign idx_ok = wb_adr_i[1:0] == 2'b00;

   // answer one cycle after the strobe, for every address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (ce_i) begin
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= {24'h000000, rd_byte};
         end
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      if (idx_ok) begin
         if (hit(reg_idx, REG_DCM_IDX)) begin
            rd_byte = dcm_r;
         end else if (hit(reg_idx, REG_LRC_IDX)) begin
            rd_byte = lrc_r;
         end else if (hit(reg_idx, REG_PLL_IDX)) begin
            rd_byte[PLL_LOCK_BIT] = lock_r;
         end else if (hit(reg_idx, REG_QC_IDX)) begin
            rd_byte = qc_r;
         end else if (hit(reg_idx, REG_CTRL_IDX)) begin
            rd_byte = ctrl_r;
         end else if (hit(reg_idx, REG_RES_IDX)) begin
            rd_byte = res_r;
         end else if (hit(reg_idx, REG_CLKLO_IDX)) begin
            rd_byte = clklo_r;
         end else if (hit(reg_idx, REG_CLKHI_IDX)) begin
            rd_byte = clkhi_r;
         end else if (hit(reg_idx, REG_STAT_IDX)) begin
            rd_byte = {1'b0, rate_fresh, state_r, lrc_match, low_need, rate_ok, cfg_ok};
         end else if (hit(reg_idx, REG_RATELO_IDX)) begin
            rd_byte = rate_r[7:0];
         end else if (hit(reg_idx, REG_RATEHI_IDX)) begin
            rd_byte = rate_r[15:8];
         end else begin
            rd_byte = 8'h00;
         end
      end
   end

   // -----------------------------------------------------------------
   // writable registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dcm_r <= DCM_RST;
         lrc_r <= LRC_RST;
         qc_r <= QC_RST;
         ctrl_r <= CTRL_RST;
         res_r <= RES_RST;
         clklo_r <= CLKLO_RST;
         clkhi_r <= CLKHI_RST;
      end else if (ce_i && wb_wr && idx_ok) begin
         if (hit(reg_idx, REG_DCM_IDX)) begin
            dcm_r <= wb_dat_i[7:0];
         end
         if (hit(reg_idx, REG_LRC_IDX)) begin
            lrc_r <= wb_dat_i[7:0];
         end
         if (hit(reg_idx, REG_QC_IDX)) begin
            qc_r <= wb_dat_i[7:0];
         end
         if (hit(reg_idx, REG_CTRL_IDX)) begin
            ctrl_r <= wb_dat_i[7:0];
         end
         if (hit(reg_idx, REG_RES_IDX)) begin
            res_r <= wb_dat_i[7:0];
         end
         if (hit(reg_idx, REG_CLKLO_IDX)) begin
            clklo_r <= wb_dat_i[7:0];
         end
         if (hit(reg_idx, REG_CLKHI_IDX)) begin
            clkhi_r <= wb_dat_i[7:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // configuration checks
   // -----------------------------------------------------------------
   // basic link parameters from the code
   sqc_qcfg_decode u_decode (
      .code_i(qc_r),
      .nprime8_i(ctrl_r[CTRL_NP8_BIT]),
      .cfg_o(dec_cfg)
   );

   always_comb begin
      case (ctrl_r[CTRL_DDC_LSB +: 2])
         2'b00: virt_m = 3'd1;
         2'b01: virt_m = ctrl_r[CTRL_CPLX_BIT] ? 3'd2 : 3'd1;
         2'b10: virt_m = ctrl_r[CTRL_CPLX_BIT] ? 3'd4 : 3'd2;
         default: virt_m = 3'd0;
      endcase
   end
   assign m_ok = dec_cfg.convs == virt_m;

   // resolution and control bits per word width
   assign res_n = res_r[RES_N_LSB +: 5];
   assign res_cs = res_r[RES_CS_LSB +: 2];
   always_comb begin
      if (ctrl_r[CTRL_NP8_BIT]) begin
         res_ok = (res_n >= 5'd7) && (res_n <= 5'd8) && (res_cs <= 2'd1);
      end else begin
         res_ok = (res_n >= 5'd8) && (res_n <= 5'd16);
      end
   end
   assign cfg_ok = dec_cfg.ok && m_ok && res_ok;

   // -----------------------------------------------------------------
   // lane rate computation
   // -----------------------------------------------------------------
   // M * N' * 10 * fadc over 8 * L * dcm
   // fout is fadc over the decimation ratio
   assign nprime = ctrl_r[CTRL_NP8_BIT] ? 5'd8 : 5'd16;
   assign num = 32'(dec_cfg.convs) * 32'(nprime) * 32'd10 * 32'({clkhi_r, clklo_r});
   // a ratio of zero is read as one so the divider never sees zero
   assign den = 16'(dec_cfg.lanes) * 16'd8 * ((dcm_r == 8'h00) ? 16'd1 : 16'(dcm_r));

   sqc_rate_div u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .start_i(dirty_r && dec_cfg.ok),
      .num_i(num),
      .den_i(den),
      .busy_o(div_busy),
      .done_o(div_done),
      .quo_o(div_quo)
   );

   // any settings write stales the result and restarts the divider
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dirty_r <= 1'b1;
      end else if (ce_i) begin
         if (wb_wr) begin
            dirty_r <= 1'b1;
         end else if (!div_busy && dec_cfg.ok) begin
            dirty_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate_r <= '0;
         have_rate_r <= 1'b0;
      end else if (ce_i) begin
         if (div_done) begin
            rate_r <= (div_quo[31:16] != 16'h0000) ? 16'hFFFF : div_quo[15:0];
            have_rate_r <= 1'b1;
         end
      end
   end

   // the quotient lands in rate_r one cycle after done, so done still means stale
   assign rate_fresh = have_rate_r && !dirty_r && !div_busy && !div_done;
   // refuse rates outside the supported range
   assign rate_ok = (rate_r >= RATE_MIN_MBPS) && (rate_r <= RATE_MAX_MBPS);
   // low rate mode needed below 6.25 Gbps
   // it must be off from 6.25 Gbps upward
   assign low_need = rate_r < RATE_LOW_MBPS;
   assign lrc_match = lrc_r[LRC_LOW_BIT] == low_need;
   assign all_ok = cfg_ok && rate_fresh && rate_ok && lrc_match;

   // -----------------------------------------------------------------
   // power sequencing and serializer lock
   // -----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SQC_DOWN: begin
            // settings are taken only on power-up
            if (!ctrl_r[CTRL_PWRDN_BIT] && all_ok) begin
               state_nxt = SQC_LOCK;
            end
         end
         SQC_LOCK: begin
            if (ctrl_r[CTRL_PWRDN_BIT]) begin
               state_nxt = SQC_DOWN;
            end else if (lock_cnt_r == 11'(LOCK_CYC - 1)) begin
               state_nxt = SQC_UP;
            end
         end
         SQC_UP: begin
            if (ctrl_r[CTRL_PWRDN_BIT]) begin
               state_nxt = SQC_DOWN;
            end
         end
         default: state_nxt = SQC_DOWN;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= SQC_DOWN;
      end else if (ce_i) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_cnt_r <= '0;
      end else if (ce_i) begin
         if (state_r == SQC_LOCK) begin
            lock_cnt_r <= lock_cnt_r + 11'd1;
         end else begin
            lock_cnt_r <= '0;
         end
      end
   end

   // lock held only while the link runs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_r <= 1'b0;
      end else if (ce_i) begin
         lock_r <= state_nxt == SQC_UP;
      end
   end

   // active settings frozen while the link is up, so live edits stay harmless
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link_cfg_o <= '0;
         link_nprime8_o <= 1'b0;
         lane_rate_mbps_o <= '0;
      end else if (ce_i && state_r == SQC_DOWN && state_nxt == SQC_LOCK) begin
         link_cfg_o <= dec_cfg;
         link_nprime8_o <= ctrl_r[CTRL_NP8_BIT];
         lane_rate_mbps_o <= rate_r;
      end
   end

   assign link_up_o = lock_r;

   // -----------------------------------------------------------------
   // lane enables and converter slots
   // -----------------------------------------------------------------
   logic cplx_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cplx_r <= 1'b0;
      end else if (ce_i && state_r == SQC_DOWN && state_nxt == SQC_LOCK) begin
         cplx_r <= ctrl_r[CTRL_CPLX_BIT];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         // lanes enabled together as one link
         assign serial_lane_outputs_en_o[gi] = lock_r && (3'(gi) < link_cfg_o.lanes);
         // odd converter of each pair carries Q
         assign conv_q_slot_o[gi] = cplx_r && (gi % 2 == 1) && (3'(gi) < link_cfg_o.convs);
      end
   endgenerate

endmodule

// ---- sqc_link_cfg_props.sv ----
// concurrent checks on the link quick-configuration block ports
`timescale 1ns/10ps
module sqc_link_cfg_props
   import sqc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [3:0] serial_lane_outputs_en_o,
   input sqc_cfg_s link_cfg_o,
   input wire logic link_nprime8_o,
   input wire logic link_up_o,
   input wire logic [15:0] lane_rate_mbps_o,
   input wire logic [3:0] conv_q_slot_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("request not acknowledged one cycle later");
   a_ack_one_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_lane_enable_mask: assert property ({1'b0, serial_lane_outputs_en_o} == (link_up_o ?
      ((5'h01 << link_cfg_o.lanes) - 5'h01) : 5'h00))
      else $error("lane enables do not match lane count");
   a_up_cfg_ok: assert property (link_up_o |-> link_cfg_o.ok)
      else $error("link up with invalid configuration");
   a_cfg_held_up: assert property (link_up_o && $past(link_up_o) |-> $stable(link_cfg_o)
      && $stable(lane_rate_mbps_o))
      else $error("settings changed while link up");
   a_rate_in_range: assert property (link_up_o |-> lane_rate_mbps_o >= RATE_MIN_MBPS
      && lane_rate_mbps_o <= RATE_MAX_MBPS)
      else $error("link up with lane rate out of range");
   a_hd_one_octet: assert property (link_up_o && link_cfg_o.hd |-> link_cfg_o.octets == 4'h1
      && !link_nprime8_o)
      else $error("high density with wrong frame size");
   a_q_odd_only: assert property ((conv_q_slot_o & 4'h5) == 4'h0)
      else $error("quadrature on an even converter");

   c_link_up: cover property ($rose(link_up_o));
   c_hd_up: cover property (link_up_o && link_cfg_o.hd);
   c_np8_up: cover property (link_up_o && link_nprime8_o);
endmodule

bind sqc_link_cfg sqc_link_cfg_props i_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .serial_lane_outputs_en_o(serial_lane_outputs_en_o), .link_cfg_o(link_cfg_o),
   .link_nprime8_o(link_nprime8_o), .link_up_o(link_up_o),
   .lane_rate_mbps_o(lane_rate_mbps_o), .conv_q_slot_o(conv_q_slot_o));

// ---- sqc_rx_model.sv ----
// behavioural link receiver watching the enabled serial lanes
`timescale 1ns/10ps
module sqc_rx_model
   import sqc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] lane_en_i,
   input wire logic link_up_i,
   input sqc_cfg_s cfg_i,
   output logic [2:0] lanes_seen_o,
   output logic [5:0] k_o
);
   // one link: count every active lane
   always_ff @(posedge clk_i) begin
      if (rst_i || !link_up_i) begin
         lanes_seen_o <= 3'h0;
      end else begin
         lanes_seen_o <= 3'($countones(lane_en_i));
      end
   end
   always_ff @(posedge clk_i) begin
      case (cfg_i.octets)
         4'h1: k_o <= 6'h14;
         4'h2: k_o <= 6'h0C;
         4'h4: k_o <= 6'h08;
         default: k_o <= 6'h20;
      endcase
   end
endmodule

// ---- tb_serial_link_quick_config.sv ----
// self-checking bench: register access, code table, power-up and refusals
`timescale 1ns/10ps
module tb_serial_link_quick_config
   import sqc_pkg::*;
;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [ADR_W-1:0] wb_adr = '0;
   logic [3:0] wb_sel = 4'hF;
   logic [31:0] wb_dat = 32'h0, wb_dat_o;
   logic wb_ack_o, link_nprime8_o, link_up_o;
   logic [3:0] lane_en, conv_q_slot_o;
   sqc_cfg_s link_cfg_o;
   logic [15:0] lane_rate_mbps_o;
   logic [2:0] lanes_seen;
   logic [5:0] k_seen;
   int n_mismatch = 0, samples_checked = 0;
   logic [31:0] tbl [25] = '{32'h00111210, 32'h04021111, 32'h04121220, 32'h08041121,
      32'h08141240, 32'h00A12410, 32'h04922210, 32'h08842111, 32'h08942220, 32'h01314810,
      32'h05224410, 32'h09144210, 32'h10011110, 32'h10111220, 32'h14021120, 32'h14121240,
      32'h14221480, 32'h18041140, 32'h18141280, 32'h10912210, 32'h14822110, 32'h14922220,
      32'h18842120, 32'h18942240, 32'h18A42480};

   always #4 clk_i = ~clk_i;

   sqc_link_cfg i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .serial_lane_outputs_en_o(lane_en), .link_cfg_o(link_cfg_o),
      .link_nprime8_o(link_nprime8_o), .link_up_o(link_up_o),
      .lane_rate_mbps_o(lane_rate_mbps_o), .conv_q_slot_o(conv_q_slot_o));
   sqc_rx_model i_rx (.clk_i(clk_i), .rst_i(rst_i), .lane_en_i(lane_en), .link_up_i(link_up_o),
      .cfg_i(link_cfg_o), .lanes_seen_o(lanes_seen), .k_o(k_seen));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] d,
      output logic [7:0] q);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {idx, 2'b00};
      wb_dat <= {24'h000000, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, idx, d, q);
   endtask

   task automatic rd(input string nm, input logic [11:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, idx, 8'h00, q);
      chk(nm, {24'h0, exp}, {24'h0, q});
   endtask

   // a setting that must keep the link down, then put back
   task automatic neg(input string nm, input logic [11:0] idx, input logic [7:0] bad,
      input logic [7:0] good, input logic [7:0] ctl);
      wr(idx, bad);
      wr(REG_CTRL_IDX, ctl);
      repeat (1400) @(posedge clk_i);
      chk(nm, 32'h0, {31'h0, link_up_o});
      wr(REG_CTRL_IDX, 8'h17);
      wr(idx, good);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clk_i);
      n_mismatch++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      stop_test();
   end

   initial begin
      logic [31:0] e;
      logic [7:0] ctl;
      int l, m, np, decimation_ratio_setting, r, n;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd("dcm reset", REG_DCM_IDX, DCM_RST);
      rd("lrc reset", REG_LRC_IDX, LRC_RST);
      rd("qc reset", REG_QC_IDX, QC_RST);
      rd("lock reset", REG_PLL_IDX, 8'h00);
      rd("unmapped", 12'h100, 8'h00);
      wb_sel <= 4'h0;
      wr(REG_DCM_IDX, 8'h55);
      wb_sel <= 4'hF;
      rd("dcm no sel", REG_DCM_IDX, DCM_RST);
      wr(REG_PLL_IDX, 8'hFF);
      rd("lock read only", REG_PLL_IDX, 8'h00);
      // 2000 MHz sample clock with a decimation ratio picked per code keeps every code inside the lane rate window
      wr(REG_CLKLO_IDX, 8'hD0);
      wr(REG_CLKHI_IDX, 8'h07);
      foreach (tbl[i]) begin
         e = tbl[i];
         l = e[19:16];
         m = e[15:12];
         np = e[28] ? 8 : 16;
         ctl = 8'h01 | (e[28] ? 8'h02 : 8'h00) | (m == 2 ? 8'h14 : (m == 4 ? 8'h18 : 8'h00));
         decimation_ratio_setting = 1;
         while (m * np * 20000 / (8 * l * decimation_ratio_setting) > 12500) decimation_ratio_setting++;
         r = m * np * 20000 / (8 * l * decimation_ratio_setting);
         wr(REG_CTRL_IDX, ctl);
         wr(REG_QC_IDX, e[27:20]);
         wr(REG_DCM_IDX, 8'(decimation_ratio_setting));
         wr(REG_RES_IDX, e[28] ? 8'h08 : 8'h0E);
         wr(REG_LRC_IDX, r < 6250 ? 8'h10 : 8'h00);
         wr(REG_CTRL_IDX, ctl & 8'hFE);
         n = 0;
         while (link_up_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
         end
         @(posedge clk_i);
         chk("link up", 32'h1, {31'h0, link_up_o});
         chk("cfg", {16'h0, e[18:16], e[14:12], e[11:4], e[0], 1'b1}, {16'h0, link_cfg_o});
         chk("rate", r, {16'h0, lane_rate_mbps_o});
         chk("lanes", (32'h1 << l) - 1, {28'h0, lane_en});
         chk("rx lanes", l, {29'h0, lanes_seen});
         chk("q slots", m == 4 ? 32'hA : (m == 2 ? 32'h2 : 32'h0), {28'h0, conv_q_slot_o});
         chk("np8", e[28], {31'h0, link_nprime8_o});
         chk("k", 32'h1, {31'h0, k_seen[1:0] == 2'b00 && k_seen <= 6'h20 &&
            k_seen >= (e[11:8] == 4'h1 ? 6'h14 : (e[11:8] == 4'h2 ? 6'h0C : 6'h08))});
         rd("lock", REG_PLL_IDX, 8'h80);
      end
      wr(REG_CTRL_IDX, 8'h17);
      @(posedge clk_i);
      chk("down", 32'h0, {31'h0, link_up_o});
      neg("lrc mismatch", REG_LRC_IDX, 8'h10, 8'h00, 8'h16);
      neg("bad resolution", REG_RES_IDX, 8'h0E, 8'h08, 8'h16);
      neg("bad code", REG_QC_IDX, 8'h8A, 8'h8A, 8'h14);
      neg("m mismatch", REG_QC_IDX, 8'h8A, 8'h8A, 8'h1A);
      stop_test();
   end
endmodule
